// *** msp_top.sv ***
`timescale 1ns/1ps
module msp_top
  import msp_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic serial_in_line,
  input wire logic data_address_flag,
  input wire logic controller_target_sel_n,
  input wire logic serial_shift_clock,
  input wire logic module_sel_n,
  input wire logic scan_advance_clock,
  input wire logic output_enable_strap,
  input wire logic cfg_ready,
  output logic serial_out_line_o,
  output logic serial_out_line_oe,
  output logic [2:0] channel_counter,
  output logic temp_sel,
  output logic cfg_valid,
  output logic [CFG_W-1:0] cfg_data,
  output logic cfg_overflow
);

  // ==========================================================
  // Input synchronisers
  msp_pins_t pins_raw, meta_q, sync_q, prev_q;
  logic strap_meta_q, strap_q;

  always_comb begin
    pins_raw.serial_in_line = serial_in_line;
    pins_raw.data_address_flag = data_address_flag;
    pins_raw.controller_target_sel_n = controller_target_sel_n;
    pins_raw.serial_shift_clock = serial_shift_clock;
    pins_raw.module_sel_n = module_sel_n;
    pins_raw.scan_advance_clock = scan_advance_clock;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= 6'h06;
      sync_q <= 6'h06;
      prev_q <= 6'h06;
      strap_meta_q <= 1'b0;
      strap_q <= 1'b0;
    end else begin
      meta_q <= pins_raw;
      sync_q <= meta_q;
      prev_q <= sync_q;
      strap_meta_q <= output_enable_strap;
      strap_q <= strap_meta_q;
    end
  end

  logic shift_rise, shift_fall, scan_rise, selected, sel_fall;
  always_comb begin
    shift_rise = sync_q.serial_shift_clock && !prev_q.serial_shift_clock;
    shift_fall = !sync_q.serial_shift_clock && prev_q.serial_shift_clock;
    scan_rise = sync_q.scan_advance_clock && !prev_q.scan_advance_clock;
    selected = !sync_q.module_sel_n && sync_q.controller_target_sel_n;
    sel_fall = !selected && !prev_q.module_sel_n && prev_q.controller_target_sel_n;
  end

  // ==========================================================
  // Serial engine
  msp_state_t st_q, st_d;
  logic [CFG_W-1:0] sh_q, sh_d;
  logic [4:0] bitcnt_q, bitcnt_d;
  logic [ID_W-1:0] id_q, id_d;
  logic [5:0] idcnt_q, idcnt_d;
  logic out_q, out_d, oe_q, oe_d;
  logic push, fifo_ready, ovf_q, ovf_d;

  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    bitcnt_d = bitcnt_q;
    id_d = id_q;
    idcnt_d = idcnt_q;
    out_d = out_q;
    push = 1'b0;
    ovf_d = ovf_q;
    oe_d = strap_q && selected;
    case (st_q)
      ST_IDLE: begin
        id_d = ID_VALUE;
        idcnt_d = '0;
        bitcnt_d = '0;
        out_d = 1'b0;
        if (selected) begin
          st_d = sync_q.data_address_flag ? ST_READ : ST_WRITE;
        end
      end
      ST_WRITE: begin
        if (!selected) begin
          st_d = ST_IDLE;
        end else if (sync_q.data_address_flag) begin
          st_d = ST_READ;
        end else if (shift_rise) begin
          sh_d = {sh_q[CFG_W-2:0], sync_q.serial_in_line};
          bitcnt_d = 5'(bitcnt_q + 1'b1);
          if (bitcnt_q == 5'(CFG_W - 1)) begin
            bitcnt_d = '0;
            push = 1'b1;
            if (!fifo_ready) begin
              ovf_d = 1'b1;
            end
          end
        end
      end
      ST_READ: begin
        if (!selected) begin
          st_d = ST_IDLE;
        end else if (!sync_q.data_address_flag) begin
          st_d = ST_WRITE;
        end else begin
          if (shift_fall) begin
            out_d = (idcnt_q < ID_BITS) ? id_q[ID_W-1] : 1'b0;
          end
          if (shift_rise && idcnt_q < ID_BITS) begin
            id_d = {id_q[ID_W-2:0], 1'b0};
            idcnt_d = 6'(idcnt_q + 1'b1);
          end
        end
      end
      default: st_d = ST_IDLE;
    endcase
    if (sel_fall) begin
      ovf_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= ST_IDLE;
      sh_q <= CFG_RST;
      bitcnt_q <= '0;
      id_q <= '0;
      idcnt_q <= '0;
      out_q <= 1'b0;
      oe_q <= 1'b0;
      ovf_q <= 1'b0;
    end else begin
      st_q <= st_d;
      sh_q <= sh_d;
      bitcnt_q <= bitcnt_d;
      id_q <= id_d;
      idcnt_q <= idcnt_d;
      out_q <= out_d;
      oe_q <= oe_d;
      ovf_q <= ovf_d;
    end
  end

  // ==========================================================
  // Configuration word buffer
  logic f_valid;
  logic [CFG_W-1:0] f_data;
  logic cv_q, cv_d;
  logic [CFG_W-1:0] cd_q, cd_d;

  msp_fifo #(.WIDTH(CFG_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data(sh_d),
    .out_valid(f_valid),
    .out_ready(!cv_q || cfg_ready),
    .out_data(f_data)
  );

  always_comb begin
    cv_d = cv_q;
    cd_d = cd_q;
    if (!cv_q || cfg_ready) begin
      cv_d = f_valid;
      if (f_valid) begin
        cd_d = f_data;
      end
    end
  end

  // ==========================================================
  // Channel counter
  msp_mux_t mux_q, mux_d;
  always_comb begin
    mux_d = mux_q;
    if (scan_rise) begin
      mux_d.channel = (mux_q.channel == CHAN_LAST) ? CHAN_RST : 3'(mux_q.channel + 1'b1);
    end
    mux_d.temp_sel = (mux_d.channel == CHAN_TEMP);
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mux_q <= {CHAN_RST, 1'b0};
      cv_q <= 1'b0;
      cd_q <= CFG_RST;
    end else begin
      mux_q <= mux_d;
      cv_q <= cv_d;
      cd_q <= cd_d;
    end
  end

  assign serial_out_line_o = out_q;
  assign serial_out_line_oe = oe_q;
  assign channel_counter = mux_q.channel;
  assign temp_sel = mux_q.temp_sel;
  assign cfg_valid = cv_q;
  assign cfg_data = cd_q;
  assign cfg_overflow = ovf_q;
endmodule

// *** msp_pkg.sv ***
// Summary of operation
// - Flag low means data bits for configuration; high means address or identification read.
// - Controller-target select low directs serial input to controller slot; high to a module.
// - Serial input bits are captured into module registers using the shift clock.
// - Each scan clock pulse increments the channel counter to the next channel.
// - Serial output drives the return line only when the strap is in position one.
// - Channel counter selects one of four inputs or the temperature sensor.
// - Channel counter advances on the rising edge of the scan clock.
// - Bits move most significant first; the shift clock rising edge captures each bit.
// - In read mode, 32 identification bits return, then zeros until deselect reloads.
package msp_pkg;

  // ==========================================================
  // Widths and values
  localparam int CFG_W = 16;
  localparam int ID_W = 32;
  localparam logic [5:0] ID_BITS = 6'h20;
  localparam logic [CFG_W-1:0] CFG_RST = 16'h0000;
  localparam logic [2:0] CHAN_LAST = 3'h4;
  localparam logic [2:0] CHAN_TEMP = 3'h4;
  localparam logic [2:0] CHAN_RST = 3'h0;
  localparam int FIFO_DEPTH = 8;
  // Arbitrary identification value
  localparam logic [ID_W-1:0] ID_VALUE = 32'h5a3c_0001;

  // ==========================================================
  // Types
  typedef struct packed {
    logic serial_in_line;
    logic data_address_flag;
    logic controller_target_sel_n;
    logic serial_shift_clock;
    logic module_sel_n;
    logic scan_advance_clock;
  } msp_pins_t;

  typedef struct packed {
    logic [2:0] channel;
    logic temp_sel;
  } msp_mux_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WRITE = 3'b010,
    ST_READ = 3'b100
  } msp_state_t;

endpackage

// *** msp_fifo.sv ***
`timescale 1ns/1ps
module msp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wp_d = push ? AW'(wp_q + 1'b1) : wp_q;
    rp_d = pop ? AW'(rp_q + 1'b1) : rp_q;
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = (AW+1)'(cnt_q + 1'b1);
    end else if (pop && !push) begin
      cnt_d = (AW+1)'(cnt_q - 1'b1);
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rp_q];
endmodule

// *** msp_top_sva.sv ***
`timescale 1ns/1ps
module msp_top_sva
  import msp_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic module_sel_n,
  input wire logic controller_target_sel_n,
  input wire logic scan_advance_clock,
  input wire logic output_enable_strap,
  input wire logic cfg_ready,
  input wire logic serial_out_line_oe,
  input wire logic [2:0] channel_counter,
  input wire logic temp_sel,
  input wire logic cfg_valid,
  input wire logic [CFG_W-1:0] cfg_data,
  input wire logic cfg_overflow
);
  // ==========
  // Properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  property p_oe; serial_out_line_oe |-> $past(output_enable_strap && !module_sel_n && controller_target_sel_n, 3);
  endproperty
  a_oe: assert property (p_oe) else $error("return line driven without cause");
  property p_temp; temp_sel == (channel_counter == CHAN_TEMP); endproperty
  a_temp: assert property (p_temp) else $error("temp select mismatch");
  property p_range; channel_counter <= CHAN_LAST; endproperty
  a_range: assert property (p_range) else $error("channel out of range");
  property p_step; $changed(channel_counter) |->
    channel_counter == ($past(channel_counter) == CHAN_LAST ? CHAN_RST : $past(channel_counter) + 3'h1); endproperty
  a_step: assert property (p_step) else $error("channel step wrong");
  property p_scan; $rose(scan_advance_clock) |-> ##[2:6] $changed(channel_counter); endproperty
  a_scan: assert property (p_scan) else $error("scan edge not followed");
  property p_quiet; !scan_advance_clock [*8] |=> $stable(channel_counter); endproperty
  a_quiet: assert property (p_quiet) else $error("channel moved without scan");
  property p_hold; cfg_valid && !cfg_ready |=> cfg_valid && $stable(cfg_data); endproperty
  a_hold: assert property (p_hold) else $error("word not held");
  property p_ovf; $rose(cfg_overflow) |-> cfg_valid; endproperty
  a_ovf: assert property (p_ovf) else $error("overflow with empty queue");
endmodule
bind msp_top msp_top_sva chk (.core_clk(core_clk), .sys_rst(sys_rst), .module_sel_n(module_sel_n),
  .controller_target_sel_n(controller_target_sel_n), .scan_advance_clock(scan_advance_clock),
  .output_enable_strap(output_enable_strap), .cfg_ready(cfg_ready), .serial_out_line_oe(serial_out_line_oe),
  .channel_counter(channel_counter), .temp_sel(temp_sel), .cfg_valid(cfg_valid), .cfg_data(cfg_data),
  .cfg_overflow(cfg_overflow));

// *** msp_ctl_model.sv ***
`timescale 1ns/1ps
module msp_ctl_model
  import msp_pkg::*;
(
  input wire logic core_clk,
  input wire logic serial_return,
  output msp_pins_t pins
);
  // ==========
  // Controller pins, shift clock idles high
  initial pins = 6'h16;
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic sel(input logic on, input logic tgt);
    pins.controller_target_sel_n = tgt;
    pins.module_sel_n = !on;
    step(6);
  endtask
  task automatic xfer(input logic flag, input logic [31:0] v, input int n, output logic [31:0] got);
    got = '0;
    pins.data_address_flag = flag;
    step(6);
    for (int i = n - 1; i >= 0; i--) begin
      pins.serial_in_line = v[i];
      pins.serial_shift_clock = 1'b0;
      step(6);
      got = {got[30:0], serial_return};
      pins.serial_shift_clock = 1'b1;
      step(7);
    end
    pins.serial_in_line = ~pins.serial_in_line;
  endtask
  task automatic scan();
    pins.scan_advance_clock = 1'b1;
    step(6);
    pins.scan_advance_clock = 1'b0;
    step(7);
  endtask
endmodule

// *** module_serial_port_decode_tb.sv ***
`timescale 1ns/1ps
module module_serial_port_decode_tb;
  import msp_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic strap = 1'b1;
  logic cfg_ready = 1'b0;
  logic so, soe, temp_sel, cfg_valid, cfg_overflow;
  logic [2:0] chan;
  logic [CFG_W-1:0] cfg_data;
  msp_pins_t pins;
  logic [CFG_W-1:0] exp_q[$];
  int num_errors = 0;
  int compares = 0;
  logic [31:0] rng = 32'h0001_1c17;
  // Released return line shows the inverse of its last level
  wire line = soe ? so : ~so;
  always #2.5 core_clk = ~core_clk;
  msp_ctl_model ctl (.core_clk(core_clk), .serial_return(line), .pins(pins));
  msp_top dut (.core_clk(core_clk), .sys_rst(sys_rst), .serial_in_line(pins.serial_in_line),
    .data_address_flag(pins.data_address_flag), .controller_target_sel_n(pins.controller_target_sel_n),
    .serial_shift_clock(pins.serial_shift_clock), .module_sel_n(pins.module_sel_n),
    .scan_advance_clock(pins.scan_advance_clock), .output_enable_strap(strap), .cfg_ready(cfg_ready),
    .serial_out_line_o(so), .serial_out_line_oe(soe), .channel_counter(chan), .temp_sel(temp_sel),
    .cfg_valid(cfg_valid), .cfg_data(cfg_data), .cfg_overflow(cfg_overflow));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (num_errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========
  // Word monitor
  always @(negedge core_clk) begin
    if (cfg_valid === 1'b1 && cfg_ready === 1'b1) begin
      if (exp_q.size() == 0) check(cfg_data, 32'hffff_ffff);
      else check(cfg_data, exp_q.pop_front());
    end
  end
  initial begin
    #300000;
    num_errors++;
    final_report();
  end
  initial begin
    logic [31:0] got;
    repeat (20) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    ctl.step(4);
    check(chan, 32'h0);
    for (int i = 1; i <= 6; i++) begin
      ctl.scan();
      check(chan, 32'(i % 5));
      check(temp_sel, 32'(i % 5 == 4));
    end
    ctl.sel(1'b1, 1'b1);
    // Output register holds one word beyond the queue depth
    for (int i = 0; i <= FIFO_DEPTH + 1; i++) begin
      rng = xs(rng);
      if (i <= FIFO_DEPTH) exp_q.push_back(rng[15:0]);
      ctl.xfer(1'b0, rng, CFG_W, got);
    end
    ctl.step(8);
    check(cfg_overflow, 32'h1);
    ctl.sel(1'b0, 1'b1);
    ctl.step(8);
    check(cfg_overflow, 32'h0);
    ctl.xfer(1'b0, xs(rng), CFG_W, got);
    ctl.sel(1'b1, 1'b0);
    ctl.xfer(1'b0, xs(rng), CFG_W, got);
    repeat (300) begin
      rng = xs(rng);
      @(posedge core_clk);
      #1 cfg_ready = rng[0];
    end
    check(exp_q.size(), 32'h0);
    ctl.sel(1'b1, 1'b1);
    check(soe, 32'h1);
    ctl.xfer(1'b1, 32'h0, ID_W, got);
    check(got, ID_VALUE);
    ctl.xfer(1'b1, 32'h0, 4, got);
    check(got, 32'h0);
    ctl.sel(1'b0, 1'b1);
    ctl.sel(1'b1, 1'b1);
    ctl.xfer(1'b1, 32'h0, 8, got);
    check(got, 32'(ID_VALUE[31:24]));
    strap = 1'b0;
    ctl.step(8);
    check(soe, 32'h0);
    final_report();
  end
endmodule
